// file: i2c_flags_pkg.sv
// constants for the two-wire status-flag block: register offsets, flag positions,
// reset values and synchroniser depth.
// assumes a 32-bit word bus with byte offsets and 8-bit registers in the low bits.
// Behaviour
// - holding moved to shifter sets tx empty
// - direction set, start, slave-to-tx set tx empty
// - read-then-write-0 or holding write clears tx empty
// - ninth scl rise with tx empty sets tx end
// - sync format last tx bit sets tx end
// - read-then-write-0 or holding write clears tx end
// - rx transfer sets full; read clears
// - missing ack while transmitting with judgment on sets nack
// - master stop after a frame sets stop
// - slave stop needs prior address match
// - bit 2 arbitration or overrun by format
// - master tx sda mismatch at scl rise
// - start seen while releasing sda as master
// - sync rx last bit while full overruns
// - nack, stop, bit 2 clear by read-write-0
// - all six flags reset to zero
// - written ones ignored, status writes never set
// - format select 0 two-wire, 1 synchronous
package i2c_flags_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_OWN_ADDR = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_TX_HOLD = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_RX_DATA = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h18;

	// flag positions in bus_status_flags
	localparam int unsigned BIT_TX_EMPTY = 7;
	localparam int unsigned BIT_TX_END = 6;
	localparam int unsigned BIT_RX_FULL = 5;
	localparam int unsigned BIT_NO_ACK = 4;
	localparam int unsigned BIT_STOP = 3;
	localparam int unsigned BIT_ARB_OVR = 2;
	localparam logic [7:0] FLAG_MASK = 8'hFC;

	// control register fields
	localparam int unsigned BIT_ACK_JUDGE = 0;
	localparam int unsigned BIT_TX_DIR = 1;
	localparam int unsigned BIT_MASTER = 2;
	localparam logic [7:0] CONTROL_MASK = 8'h07;

	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_OWN_ADDR = 8'h00;
	localparam logic [7:0] RST_TX_HOLD = 8'hFF;
	localparam logic [7:0] RST_RX_DATA = 8'hFF;

	// scl edge index of the acknowledge clock, counted from zero
	localparam logic [3:0] ACK_EDGE = 4'h8;
	localparam logic [3:0] LAST_DATA_EDGE = 4'h7;
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	localparam int unsigned SYNC_STAGES = 3;
endpackage : i2c_flags_pkg

// file: i2c_status_flag_logic.sv
// status flags of the two-wire serial interface, with register port and interrupt.
// assumes a shift engine on the same clock that reports byte moves as one-cycle
// pulses; scl and sda pin levels arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module i2c_status_flag_logic (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [i2c_flags_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [i2c_flags_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [i2c_flags_pkg::DATA_W-1:0] reg_rdata,
	// bus pin levels, asynchronous
	input wire logic scl_pin,
	input wire logic sda_pin,
	// shift engine events, same clock
	input wire logic tx_shift_load,
	input wire logic start_issued,
	input wire logic slave_to_tx,
	input wire logic sync_tx_last_bit,
	input wire logic rx_load,
	input wire logic [7:0] rx_byte,
	input wire logic sda_internal,
	// to the shift engine
	output logic [7:0] tx_holding_reg,
	output logic [7:0] control_bits,
	output logic format_select,
	// interrupt
	output logic irq
);
	import i2c_flags_pkg::*;

	logic [7:0] flags_q, flags_d;
	logic [7:0] armed_q;
	logic [7:0] control_q;
	logic [7:0] own_address_reg_q;
	logic [7:0] tx_hold_q;
	logic [7:0] rx_data_reg_q;
	logic [7:0] irq_status_q;
	logic [7:0] irq_mask_q;
	logic [DATA_W-1:0] rdata_q;
	logic irq_q;
	logic [SYNC_STAGES-1:0] scl_sync_q, sda_sync_q;
	logic scl_lvl_q, sda_lvl_q;
	logic [3:0] edge_cnt_q;
	logic [7:0] shift_q;
	logic first_frame_q, frame_done_q, addr_match_q;

	// decoded accesses
	logic wr_status, rd_status, wr_control, wr_own, wr_hold, rd_rx, rd_irq, wr_mask;
	assign wr_status = reg_write && (reg_addr == OFS_STATUS);
	assign rd_status = reg_read && (reg_addr == OFS_STATUS);
	assign wr_control = reg_write && (reg_addr == OFS_CONTROL);
	assign wr_own = reg_write && (reg_addr == OFS_OWN_ADDR);
	assign wr_hold = reg_write && (reg_addr == OFS_TX_HOLD);
	assign rd_rx = reg_read && (reg_addr == OFS_RX_DATA);
	assign rd_irq = reg_read && (reg_addr == OFS_IRQ_STATUS);
	assign wr_mask = reg_write && (reg_addr == OFS_IRQ_MASK);

	logic sync_fmt, master, tx_dir, ack_judge;
	assign sync_fmt = own_address_reg_q[0];
	assign master = control_q[BIT_MASTER];
	assign tx_dir = control_q[BIT_TX_DIR];
	assign ack_judge = control_q[BIT_ACK_JUDGE];

	// pin synchronisers; only stages two and three are looked at
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			scl_sync_q <= '1;
			sda_sync_q <= '1;
			scl_lvl_q <= 1'b1;
			sda_lvl_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[SYNC_STAGES-2:0], scl_pin};
			sda_sync_q <= {sda_sync_q[SYNC_STAGES-2:0], sda_pin};
			if (scl_sync_q[1] == scl_sync_q[2]) begin
				scl_lvl_q <= scl_sync_q[2];
			end
			if (sda_sync_q[1] == sda_sync_q[2]) begin
				sda_lvl_q <= sda_sync_q[2];
			end
		end
	end

	// bus events from the filtered levels
	logic scl_new, sda_new, scl_rise, start_seen, stop_seen;
	assign scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_lvl_q;
	assign sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_lvl_q;
	assign scl_rise = !sync_fmt && !scl_lvl_q && scl_new;
	assign start_seen = !sync_fmt && scl_lvl_q && scl_new && sda_lvl_q && !sda_new;
	assign stop_seen = !sync_fmt && scl_lvl_q && scl_new && !sda_lvl_q && sda_new;

	logic ack_clk, data_clk;
	logic [7:0] byte_now;
	assign ack_clk = scl_rise && (edge_cnt_q == ACK_EDGE);
	assign data_clk = scl_rise && (edge_cnt_q != ACK_EDGE);
	assign byte_now = {shift_q[6:0], sda_new};

	// frame tracking: bit count, first-byte address compare, frame seen
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			edge_cnt_q <= '0;
			shift_q <= '0;
			first_frame_q <= 1'b0;
			frame_done_q <= 1'b0;
			addr_match_q <= 1'b0;
		end else if (start_seen) begin
			edge_cnt_q <= '0;
			first_frame_q <= 1'b1;
			frame_done_q <= 1'b0;
			addr_match_q <= 1'b0;
		end else if (stop_seen) begin
			edge_cnt_q <= '0;
			first_frame_q <= 1'b0;
			frame_done_q <= 1'b0;
			addr_match_q <= 1'b0;
		end else if (scl_rise) begin
			if (ack_clk) begin
				edge_cnt_q <= '0;
				first_frame_q <= 1'b0;
				frame_done_q <= 1'b1;
			end else begin
				edge_cnt_q <= edge_cnt_q + 4'h1;
				shift_q <= byte_now;
			end
			// slave compares its address or the general call on the eighth edge
			if (data_clk && (edge_cnt_q == LAST_DATA_EDGE) && first_frame_q && !master) begin
				addr_match_q <= (byte_now[7:1] == own_address_reg_q[7:1]) ||
					(byte_now[7:1] == GENERAL_CALL);
			end
		end
	end

	// set events per flag
	logic tx_dir_rise;
	logic [7:0] set_vec, hw_clr, sw_clr;
	assign tx_dir_rise = wr_control && reg_wdata[BIT_TX_DIR] && !tx_dir;
	always_comb begin
		set_vec = '0;
		set_vec[BIT_TX_EMPTY] = tx_shift_load || tx_dir_rise || start_issued || slave_to_tx;
		set_vec[BIT_TX_END] = (ack_clk && flags_q[BIT_TX_EMPTY]) || (sync_fmt && sync_tx_last_bit);
		set_vec[BIT_RX_FULL] = rx_load;
		set_vec[BIT_NO_ACK] = ack_clk && tx_dir && ack_judge && sda_new;
		set_vec[BIT_STOP] = stop_seen && (master ? frame_done_q : addr_match_q);
		set_vec[BIT_ARB_OVR] = (data_clk && master && tx_dir && (sda_internal != sda_new)) ||
			(start_seen && master && sda_internal) ||
			(sync_fmt && rx_load && flags_q[BIT_RX_FULL]);
	end

	// clears: written zero only where armed by a read of one; status writes never set
	always_comb begin
		sw_clr = wr_status ? (armed_q & ~reg_wdata[7:0] & FLAG_MASK) : 8'h00;
		hw_clr = '0;
		hw_clr[BIT_TX_EMPTY] = wr_hold;
		hw_clr[BIT_TX_END] = wr_hold;
		hw_clr[BIT_RX_FULL] = rd_rx;
		flags_d = ((flags_q & ~(sw_clr | hw_clr)) | set_vec) & FLAG_MASK;
	end

	// status flags, set wins over clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			flags_q <= RST_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	// arming: a read remembers which flags were one; any status write spends it
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			armed_q <= '0;
		end else if (wr_status) begin
			armed_q <= '0;
		end else if (rd_status) begin
			armed_q <= flags_q & FLAG_MASK;
		end
	end

	// software-written registers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			control_q <= RST_CONTROL;
			own_address_reg_q <= RST_OWN_ADDR;
			tx_hold_q <= RST_TX_HOLD;
			irq_mask_q <= '0;
		end else begin
			if (wr_control) begin
				control_q <= reg_wdata[7:0] & CONTROL_MASK;
			end
			if (wr_own) begin
				own_address_reg_q <= reg_wdata[7:0];
			end
			if (wr_hold) begin
				tx_hold_q <= reg_wdata[7:0];
			end
			if (wr_mask) begin
				irq_mask_q <= reg_wdata[7:0] & FLAG_MASK;
			end
		end
	end

	// received byte lands with the full flag
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_data_reg_q <= RST_RX_DATA;
		end else if (rx_load) begin
			rx_data_reg_q <= rx_byte;
		end
	end

	// sticky event copy, cleared by its read; a same-cycle event survives
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= ((rd_irq ? 8'h00 : irq_status_q) | set_vec) & FLAG_MASK;
		end
	end

	// level interrupt, registered from the next event copy so it changes in the same cycle as the status bit
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(((rd_irq ? 8'h00 : irq_status_q) | set_vec) & irq_mask_q);
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdata_q <= '0;
		end else if (reg_read) begin
			unique case (reg_addr)
				OFS_STATUS: rdata_q <= {24'h00_0000, flags_q};
				OFS_CONTROL: rdata_q <= {24'h00_0000, control_q};
				OFS_OWN_ADDR: rdata_q <= {24'h00_0000, own_address_reg_q};
				OFS_TX_HOLD: rdata_q <= {24'h00_0000, tx_hold_q};
				OFS_RX_DATA: rdata_q <= {24'h00_0000, rx_data_reg_q};
				OFS_IRQ_STATUS: rdata_q <= {24'h00_0000, irq_status_q};
				OFS_IRQ_MASK: rdata_q <= {24'h00_0000, irq_mask_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign tx_holding_reg = tx_hold_q;
	assign control_bits = control_q;
	assign format_select = own_address_reg_q[0];
endmodule : i2c_status_flag_logic

// file: i2c_flags_properties.sv
// port checks for the status-flag block
// assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
module i2c_flags_properties (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [i2c_flags_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [i2c_flags_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [i2c_flags_pkg::DATA_W-1:0] reg_rdata,
	// events and outputs
	input wire logic tx_shift_load,
	input wire logic sync_tx_last_bit,
	input wire logic rx_load,
	input wire logic [7:0] rx_byte,
	input wire logic [7:0] tx_holding_reg,
	input wire logic format_select
);
	import i2c_flags_pkg::*;
	// a quiet cycle keeps a clear from racing the status read
	wire logic st_rd = reg_read && reg_addr == OFS_STATUS;
	wire logic quiet = !(reg_write || reg_read);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_pad; st_rd |=> reg_rdata[1:0] == 2'h0 && reg_rdata[31:8] == 24'h0; endproperty
	a_pad: assert property (p_pad) else $error("status pad bits set");
	property p_tx_empty; tx_shift_load ##1 quiet ##1 st_rd |=> reg_rdata[BIT_TX_EMPTY]; endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("tx empty not set");
	property p_tx_end;
		format_select && sync_tx_last_bit ##1 quiet ##1 st_rd |=> reg_rdata[BIT_TX_END];
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx end not set");
	property p_rx_full; rx_load ##1 quiet ##1 st_rd |=> reg_rdata[BIT_RX_FULL]; endproperty
	a_rx_full: assert property (p_rx_full) else $error("rx full not set");
	property p_rx_data;
		rx_load ##1 quiet ##1 (reg_read && reg_addr == OFS_RX_DATA)
			|=> reg_rdata[7:0] == $past(rx_byte, 3);
	endproperty
	a_rx_data: assert property (p_rx_data) else $error("rx byte lost");
	property p_overrun;
		format_select && rx_load ##1 rx_load ##1 quiet ##1 st_rd
			|=> reg_rdata[BIT_ARB_OVR] && reg_rdata[BIT_RX_FULL];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not set");
	property p_fs;
		reg_write && reg_addr == OFS_OWN_ADDR |=> {31'h0, format_select} == ($past(reg_wdata) & 32'h1);
	endproperty
	a_fs: assert property (p_fs) else $error("format select wrong");
	property p_hold;
		reg_write && reg_addr == OFS_TX_HOLD |=> {24'h0, tx_holding_reg} == ($past(reg_wdata) & 32'hFF);
	endproperty
	a_hold: assert property (p_hold) else $error("holding byte wrong");
endmodule : i2c_flags_properties
bind i2c_status_flag_logic i2c_flags_properties i_chk (.clock, .reset_n, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .tx_shift_load, .sync_tx_last_bit, .rx_load, .rx_byte,
	.tx_holding_reg, .format_select);

// file: i2c_bus_model.sv
// far-side bus party: drives one frame with ack and stop on scl and sda
// assumes pull-ups, so released lines idle high and scl stands still between frames
`timescale 1ns/1ps
module i2c_bus_model (
	// bus lines
	output logic scl_pin,
	output logic sda_pin
);
	initial begin
		scl_pin = 1'b1;
		sda_pin = 1'b1;
	end
	// 80 ns bit period, sda moves mid-low so it never looks like start or stop
	task frame(input logic [7:0] b, input logic ack);
		logic [8:0] v;
		v = {b, ack};
		// keep pin changes 3 ns off the clock edges so no sample races them
		#3;
		#40 sda_pin = 1'b0;
		#40 scl_pin = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			#20 sda_pin = v[i];
			#20 scl_pin = 1'b1;
			#40 scl_pin = 1'b0;
		end
		#20 sda_pin = 1'b0;
		#20 scl_pin = 1'b1;
		#40 sda_pin = 1'b1;
		#40;
	endtask : frame
endmodule : i2c_bus_model

// file: i2c_status_flag_logic_tb.sv
// bench for the status-flag block: event rows, then clearing, masking and frames
// assumes the checker binds itself and the bus model owns the pins
`timescale 1ns/1ps
module i2c_status_flag_logic_tb;
	import i2c_flags_pkg::*;
	typedef struct packed {logic sync_fmt; logic [4:0] ev; logic [1:0] n; logic [7:0] fl;} row_s;
	logic clock, reset_n, reg_write, reg_read, sda_internal, format_select, irq, scl_pin, sda_pin;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_q;
	logic [4:0] ev;
	logic [7:0] rx_byte, tx_holding_reg, control_bits;
	int n_fail = 0;
	int cmp_count = 0;
	// ev bits: shift load, start, slave to tx, sync last bit, rx load
	row_s rows [8] = '{{1'b0, 5'h01, 2'h1, 8'h80}, {1'b0, 5'h02, 2'h1, 8'h80},
		{1'b0, 5'h04, 2'h1, 8'h80}, {1'b0, 5'h10, 2'h1, 8'h20}, {1'b0, 5'h08, 2'h1, 8'h00},
		{1'b1, 5'h08, 2'h1, 8'h40}, {1'b1, 5'h10, 2'h2, 8'h24}, {1'b0, 5'h10, 2'h2, 8'h20}};
	// frame rows: sda_internal, byte, ack level, flags
	logic [17:0] frames [3] = '{{1'b0, 8'h00, 1'b1, 8'hD8}, {1'b1, 8'hFF, 1'b0, 8'h0C},
		{1'b0, 8'h01, 1'b0, 8'h0C}};
	i2c_status_flag_logic i_dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .scl_pin, .sda_pin, .tx_shift_load(ev[0]), .start_issued(ev[1]),
		.slave_to_tx(ev[2]), .sync_tx_last_bit(ev[3]), .rx_load(ev[4]), .rx_byte,
		.sda_internal, .tx_holding_reg, .control_bits, .format_select, .irq);
	i2c_bus_model i_bus (.scl_pin, .sda_pin);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// wide enough that concatenated outputs are compared whole
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task rd(input logic [ADDR_W-1:0] a);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask : rd
	task pulse(input logic [4:0] e, input int n);
		@(posedge clock);
		ev <= e;
		repeat (n) @(posedge clock);
		ev <= 5'h0;
	endtask : pulse
	task end_of_test;
		$display("compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	// watchdog well beyond the few microseconds the tests need
	initial begin
		#200us;
		n_fail++;
		end_of_test();
	end
	initial begin
		{reset_n, reg_write, reg_read, reg_addr, reg_wdata, ev} = '0;
		rx_byte = 8'hC3;
		sda_internal = 1'b1;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		wr(OFS_STATUS, 32'hFF);
		rd(OFS_STATUS);
		chk(rd_q, 32'h0);
		chk({irq, control_bits, tx_holding_reg}, 32'hFF);
		wr(OFS_IRQ_MASK, 32'hFC);
		foreach (rows[i]) begin
			wr(OFS_OWN_ADDR, rows[i].sync_fmt);
			pulse(rows[i].ev, rows[i].n);
			rd(OFS_STATUS);
			chk(rd_q, rows[i].fl);
			chk(irq, rows[i].fl != 0);
			wr(OFS_STATUS, 32'h0);
			rd(OFS_IRQ_STATUS);
			rd(OFS_STATUS);
			chk({irq, rd_q}, 33'h0);
		end
		// write 0 before any read must not clear, ones never clear
		pulse(5'h01, 1);
		wr(OFS_STATUS, 32'h0);
		rd(OFS_STATUS);
		wr(OFS_STATUS, 32'hFF);
		rd(OFS_STATUS);
		chk(rd_q, 32'h80);
		wr(OFS_STATUS, 32'h0);
		rd(OFS_STATUS);
		chk(rd_q, 32'h0);
		// masked interrupt, rx read clears full, unmask raises, read clears
		wr(OFS_IRQ_MASK, 32'h0);
		pulse(5'h10, 1);
		rd(OFS_RX_DATA);
		chk({irq, rd_q}, 33'hC3);
		rd(OFS_STATUS);
		chk(rd_q, 32'h0);
		wr(OFS_IRQ_MASK, 32'hFC);
		rd(OFS_STATUS);
		chk(irq, 1'b1);
		rd(OFS_IRQ_STATUS);
		chk({irq, rd_q}, 33'hA0);
		// holding write clears tx empty and tx end
		wr(OFS_OWN_ADDR, 32'h1);
		pulse(5'h09, 1);
		wr(OFS_TX_HOLD, 32'h5A);
		rd(OFS_STATUS);
		chk({tx_holding_reg, rd_q}, 40'h5A_0000_0000);
		// frames as master transmitter, ack judged
		wr(OFS_OWN_ADDR, 32'h0);
		wr(OFS_CONTROL, 32'h07);
		foreach (frames[i]) begin
			sda_internal <= frames[i][17];
			i_bus.frame(frames[i][16:9], frames[i][8]);
			rd(OFS_STATUS);
			chk(rd_q, frames[i][7:0]);
			wr(OFS_STATUS, 32'h0);
		end
		// slave: stop counts after an own-address first byte, not after another address
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_OWN_ADDR, 32'h08);
		i_bus.frame(8'h08, 1'b0);
		rd(OFS_STATUS);
		chk(rd_q, 32'h08);
		wr(OFS_STATUS, 32'h0);
		i_bus.frame(8'h0A, 1'b0);
		rd(OFS_STATUS);
		chk(rd_q, 32'h00);
		rd(OFS_OWN_ADDR);
		chk(rd_q, 32'h08);
		rd(OFS_TX_HOLD);
		chk(rd_q, 32'h5A);
		// reset in mid-run with flags and interrupt raised
		pulse(5'h11, 1);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(OFS_STATUS);
		chk({irq, rd_q}, 33'h0);
		chk({tx_holding_reg, control_bits}, 16'hFF00);
		end_of_test();
	end
endmodule : i2c_status_flag_logic_tb
